// >>> design/rmcb_map.svh
`ifndef RMCB_MAP_SVH
`define RMCB_MAP_SVH

// ==========================================
// Register offsets
`define RMCB_TERM_MAIN_ADDR 8'h52
`define RMCB_TERM_ALT_ADDR 8'h53
`define RMCB_USB_MAIN_ADDR 8'h55
`define RMCB_USB_ALT_ADDR 8'h56
`define RMCB_REF_MAIN_ADDR 8'h64
`define RMCB_REF_ALT_ADDR 8'h65
`define RMCB_REF_PIN_ADDR 8'h66

// ==========================================
// Field positions
`define RMCB_SNK_BIT 7
`define RMCB_BYP_BIT 6
`define RMCB_VOUT_HI 5
`define RMCB_VOUT_LO 1
`define RMCB_EN_BIT 0
`define RMCB_SRC_HI 7
`define RMCB_SRC_LO 6
`define RMCB_DLYH_HI 7
`define RMCB_DLYH_LO 6
`define RMCB_DLYL_HI 5
`define RMCB_DLYL_LO 4
`define RMCB_SEL_HI 3
`define RMCB_SEL_LO 2
`define RMCB_PRST_BIT 1
`define RMCB_PEN_BIT 0

// ==========================================
// Reset values and encodings
`define RMCB_PIN_RESET 8'h00
`define RMCB_RDATA_NONE 8'h00
`define RMCB_SRC_MAIN 2'h1
`define RMCB_SRC_BUS 2'h2
`define RMCB_SEL_NONE 2'h0
`define RMCB_SEL_ONE 2'h1
`define RMCB_SEL_TWO 2'h2
`define RMCB_DLY_NONE 2'h0
`define RMCB_DLY_1P5 2'h1
`define RMCB_DLY_3 2'h2
`define RMCB_RANK_MIN 3'h1
`define RMCB_RANK_MAX 3'h5

// ==========================================
// Timing
`define RMCB_CLK_MHZ 200
`define RMCB_DLY_1P5_US 1500
`define RMCB_DLY_3_US 3000
`define RMCB_DLY_6_US 6000
`define RMCB_CNT_W 21
`define RMCB_CYC(us) ((us) * `RMCB_CLK_MHZ)

`endif

// >>> design/rmcb_pkg.sv
`include "rmcb_map.svh"

package rmcb_pkg;

   // ==========================================
   // Shift delay filter states
   typedef enum logic [0:0] {
      RMCB_SH_STABLE = 1'b0,
      RMCB_SH_WAIT = 1'b1
   } rmcb_shift_e;

   // Shift delay filter state
   typedef struct packed {
      rmcb_shift_e st;
      logic level;
      logic [`RMCB_CNT_W-1:0] cnt;
   } rmcb_shift_s;

   // Register bank state
   typedef struct packed {
      logic [7:0] term_main;
      logic [7:0] term_alt;
      logic [1:0] usb_main_src;
      logic usb_main_en;
      logic [1:0] usb_alt_src;
      logic usb_alt_en;
      logic ref_main_en;
      logic ref_alt_en;
      logic [7:0] pin_ctrl;
      logic ref_def_en;
      logic [7:0] rdata;
      logic term_en;
      logic term_snk;
      logic term_byp;
      logic [4:0] term_vout;
      logic usb_en;
      logic usb_fmain;
      logic usb_fbus;
      logic usb_auto;
      logic ref_en;
      logic ref_alt;
   } rmcb_bank_s;

endpackage

// >>> design/rmcb_shift_delay.sv
`timescale 1ns/1ps
`default_nettype none
`include "rmcb_map.svh"

module rmcb_shift_delay #(
   parameter logic [`RMCB_CNT_W-1:0] CYC_1P5 = `RMCB_CNT_W'(`RMCB_CYC(`RMCB_DLY_1P5_US)),
   parameter logic [`RMCB_CNT_W-1:0] CYC_3 = `RMCB_CNT_W'(`RMCB_CYC(`RMCB_DLY_3_US)),
   parameter logic [`RMCB_CNT_W-1:0] CYC_6 = `RMCB_CNT_W'(`RMCB_CYC(`RMCB_DLY_6_US))
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Raw level and delay codes
   input wire logic level_i,
   input wire logic [1:0] rise_sel_i,
   input wire logic [1:0] fall_sel_i,
   // Delayed level
   output logic level_o
);

   // State and its next value
   rmcb_pkg::rmcb_shift_s st_reg;
   rmcb_pkg::rmcb_shift_s st_next;
   // Delay chosen for the pending edge
   logic [`RMCB_CNT_W-1:0] target;
   logic [1:0] code;

   // ==========================================
   // Edge qualification
   // A bounce back to the old level restarts the wait, so only a level
   // held for the whole delay is passed on.
   always_comb begin
      st_next = st_reg;
      code = level_i ? rise_sel_i : fall_sel_i;
      if (code == `RMCB_DLY_NONE) begin
         target = '0;
      end else if (code == `RMCB_DLY_1P5) begin
         target = CYC_1P5;
      end else if (code == `RMCB_DLY_3) begin
         target = CYC_3;
      end else begin
         target = CYC_6;
      end
      case (st_reg.st)
         rmcb_pkg::RMCB_SH_STABLE: begin
            st_next.cnt = '0;
            if (level_i != st_reg.level) begin
               if (target == '0) begin
                  st_next.level = level_i;
               end else begin
                  st_next.st = rmcb_pkg::RMCB_SH_WAIT;
                  st_next.cnt = `RMCB_CNT_W'(1);
               end
            end
         end
         rmcb_pkg::RMCB_SH_WAIT: begin
            if (level_i == st_reg.level) begin
               // Glitch: drop the pending edge
               st_next.st = rmcb_pkg::RMCB_SH_STABLE;
            end else if (st_reg.cnt >= target) begin
               st_next.level = level_i;
               st_next.st = rmcb_pkg::RMCB_SH_STABLE;
            end else begin
               st_next.cnt = st_reg.cnt + `RMCB_CNT_W'(1);
            end
         end
         default: begin
            st_next.st = rmcb_pkg::RMCB_SH_STABLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign level_o = st_reg.level;

endmodule // rmcb_shift_delay
`default_nettype wire

// >>> design/rmcb_bank.sv
// Operation
// - Check-and-load reloads every control register default
// - Alternate registers start equal to main
// - Sink/source wins over bypass when both set
// - Sink/source bit: 0 normal/bypass, 1 sink/source
// - Bypass bit: 0 normal, 1 bypass
// - Bits 5:1 carry output voltage code
// - Bit 0 enables termination regulator
// - Input field 01 main, 10 bus, else auto
// - USB enable bit; default on for rank 1-5
// - Reference enable bit 0; other bits read-only zero
// - Reference default enabled for rank 1-5
// - Rise shift delay none, 1.5, 3, 6 ms
// - Fall shift delay none, 1.5, 3, 6 ms
// - Pin select: none, pin one, two, three
// - Reset option holds reference off, restores defaults
// - Control enable clear: main only, else pin-selected
`timescale 1ns/1ps
`default_nettype none
`include "rmcb_map.svh"

module rmcb_bank #(
   // Shift delay counts, shortened in simulation
   parameter logic [`RMCB_CNT_W-1:0] CYC_1P5 = `RMCB_CNT_W'(`RMCB_CYC(`RMCB_DLY_1P5_US)),
   parameter logic [`RMCB_CNT_W-1:0] CYC_3 = `RMCB_CNT_W'(`RMCB_CYC(`RMCB_DLY_3_US)),
   parameter logic [`RMCB_CNT_W-1:0] CYC_6 = `RMCB_CNT_W'(`RMCB_CYC(`RMCB_DLY_6_US))
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Register port from the serial slave
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // Check-and-load strobe and shadow defaults
   input wire logic check_load_i,
   input wire logic nvm_term_snk_i,
   input wire logic nvm_term_byp_i,
   input wire logic [4:0] nvm_term_vout_i,
   input wire logic [2:0] nvm_term_rank_i,
   input wire logic [2:0] usb_phy_regulator_rank_i,
   input wire logic [2:0] reference_regulator_rank_i,
   // Power control pins
   input wire logic power_control_pin_one_i,
   input wire logic power_control_pin_two_i,
   input wire logic power_control_pin_three_i,
   // Mode selects from the other regulators' pin logic
   input wire logic term_alt_sel_i,
   input wire logic usb_alt_sel_i,
   // Applied termination regulator settings
   output logic term_en_o,
   output logic term_sink_source_o,
   output logic term_bypass_o,
   output logic [4:0] term_output_voltage_code_o,
   // Applied USB PHY regulator settings
   output logic usb_en_o,
   output logic usb_force_main_supply_o,
   output logic usb_force_bus_supply_o,
   output logic usb_auto_supply_o,
   // Applied reference regulator settings
   output logic ref_en_o,
   output logic ref_alt_active_o
);

   // ==========================================
   // Declarations

   // Whole bank state and its next value
   rmcb_pkg::rmcb_bank_s st_reg;
   rmcb_pkg::rmcb_bank_s st_next;
   // Raw selected pin level
   logic pin_raw;
   // Pin level after the shift delay
   logic pin_act;
   // Reference reset option in force
   logic ref_hold;
   // Loaded main defaults of the termination regulator
   logic [7:0] term_def;
   // Termination settings of the mode in force
   logic [7:0] term_use;
   // USB settings of the mode in force
   logic [1:0] usb_src;
   logic usb_on;

   // Rank code to power-up enable
   function automatic logic rank_on(input logic [2:0] rank);
      rank_on = (rank >= `RMCB_RANK_MIN) && (rank <= `RMCB_RANK_MAX);
   endfunction

   // ==========================================
   // Control pin selection

   // Pick the controlling pin; no source reads as inactive
   always_comb begin
      if (st_reg.pin_ctrl[`RMCB_SEL_HI:`RMCB_SEL_LO] == `RMCB_SEL_NONE) begin
         pin_raw = 1'b0;
      end else if (st_reg.pin_ctrl[`RMCB_SEL_HI:`RMCB_SEL_LO] == `RMCB_SEL_ONE) begin
         pin_raw = power_control_pin_one_i;
      end else if (st_reg.pin_ctrl[`RMCB_SEL_HI:`RMCB_SEL_LO] == `RMCB_SEL_TWO) begin
         pin_raw = power_control_pin_two_i;
      end else begin
         pin_raw = power_control_pin_three_i;
      end
   end

   // Rise and fall shift delays on the selected pin
   rmcb_shift_delay #(
      .CYC_1P5(CYC_1P5),
      .CYC_3(CYC_3),
      .CYC_6(CYC_6)
   ) u_shift (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .level_i(pin_raw),
      .rise_sel_i(st_reg.pin_ctrl[`RMCB_DLYH_HI:`RMCB_DLYH_LO]),
      .fall_sel_i(st_reg.pin_ctrl[`RMCB_DLYL_HI:`RMCB_DLYL_LO]),
      .level_o(pin_act)
   );

   // ==========================================
   // Next state

   // Loads, writes, reset option and applied settings in one place
   always_comb begin
      st_next = st_reg;
      term_def = {nvm_term_snk_i, nvm_term_byp_i, nvm_term_vout_i,
         rank_on(nvm_term_rank_i)};
      ref_hold = st_reg.pin_ctrl[`RMCB_PRST_BIT] & pin_act;

      // Register writes; reserved bits are not stored
      if (reg_wr_i) begin
         if (reg_addr_i == `RMCB_TERM_MAIN_ADDR) begin
            st_next.term_main = reg_wdata_i;
         end else if (reg_addr_i == `RMCB_TERM_ALT_ADDR) begin
            st_next.term_alt = reg_wdata_i;
         end else if (reg_addr_i == `RMCB_USB_MAIN_ADDR) begin
            st_next.usb_main_src = reg_wdata_i[`RMCB_SRC_HI:`RMCB_SRC_LO];
            st_next.usb_main_en = reg_wdata_i[`RMCB_EN_BIT];
         end else if (reg_addr_i == `RMCB_USB_ALT_ADDR) begin
            st_next.usb_alt_src = reg_wdata_i[`RMCB_SRC_HI:`RMCB_SRC_LO];
            st_next.usb_alt_en = reg_wdata_i[`RMCB_EN_BIT];
         end else if (reg_addr_i == `RMCB_REF_MAIN_ADDR) begin
            st_next.ref_main_en = reg_wdata_i[`RMCB_EN_BIT];
         end else if (reg_addr_i == `RMCB_REF_ALT_ADDR) begin
            st_next.ref_alt_en = reg_wdata_i[`RMCB_EN_BIT];
         end else if (reg_addr_i == `RMCB_REF_PIN_ADDR) begin
            st_next.pin_ctrl = reg_wdata_i;
         end
      end

      // Reference reset option: registers pinned to their loaded default
      if (ref_hold) begin
         st_next.ref_main_en = st_reg.ref_def_en;
         st_next.ref_alt_en = st_reg.ref_def_en;
      end

      // Check-and-load wins over a write in the same cycle
      if (check_load_i) begin
         st_next.term_main = term_def;
         st_next.term_alt = term_def;
         st_next.usb_main_src = 2'h0;
         st_next.usb_main_en = rank_on(usb_phy_regulator_rank_i);
         st_next.usb_alt_src = 2'h0;
         st_next.usb_alt_en = rank_on(usb_phy_regulator_rank_i);
         st_next.ref_def_en = rank_on(reference_regulator_rank_i);
         st_next.ref_main_en = rank_on(reference_regulator_rank_i);
         st_next.ref_alt_en = rank_on(reference_regulator_rank_i);
         st_next.pin_ctrl = `RMCB_PIN_RESET;
      end

      // Read data, reserved bits as zero, unmapped offsets as zero
      if (reg_rd_i) begin
         if (reg_addr_i == `RMCB_TERM_MAIN_ADDR) begin
            st_next.rdata = st_reg.term_main;
         end else if (reg_addr_i == `RMCB_TERM_ALT_ADDR) begin
            st_next.rdata = st_reg.term_alt;
         end else if (reg_addr_i == `RMCB_USB_MAIN_ADDR) begin
            st_next.rdata = {st_reg.usb_main_src, 5'h00, st_reg.usb_main_en};
         end else if (reg_addr_i == `RMCB_USB_ALT_ADDR) begin
            st_next.rdata = {st_reg.usb_alt_src, 5'h00, st_reg.usb_alt_en};
         end else if (reg_addr_i == `RMCB_REF_MAIN_ADDR) begin
            st_next.rdata = {7'h00, st_reg.ref_main_en};
         end else if (reg_addr_i == `RMCB_REF_ALT_ADDR) begin
            st_next.rdata = {7'h00, st_reg.ref_alt_en};
         end else if (reg_addr_i == `RMCB_REF_PIN_ADDR) begin
            st_next.rdata = st_reg.pin_ctrl;
         end else begin
            st_next.rdata = `RMCB_RDATA_NONE;
         end
      end

      // Termination regulator: mode chosen by its own pin logic
      term_use = term_alt_sel_i ? st_reg.term_alt : st_reg.term_main;
      st_next.term_en = term_use[`RMCB_EN_BIT];
      st_next.term_vout = term_use[`RMCB_VOUT_HI:`RMCB_VOUT_LO];
      st_next.term_snk = term_use[`RMCB_SNK_BIT];
      // Sink/source masks a bypass request
      st_next.term_byp = term_use[`RMCB_BYP_BIT] & ~term_use[`RMCB_SNK_BIT];

      // USB PHY regulator: supply input decode
      usb_src = usb_alt_sel_i ? st_reg.usb_alt_src : st_reg.usb_main_src;
      usb_on = usb_alt_sel_i ? st_reg.usb_alt_en : st_reg.usb_main_en;
      st_next.usb_en = usb_on;
      st_next.usb_fmain = (usb_src == `RMCB_SRC_MAIN);
      st_next.usb_fbus = (usb_src == `RMCB_SRC_BUS);
      st_next.usb_auto = (usb_src != `RMCB_SRC_MAIN) && (usb_src != `RMCB_SRC_BUS);

      // Reference regulator: reset option first, then pin-selected mode
      if (ref_hold) begin
         st_next.ref_en = 1'b0;
         st_next.ref_alt = 1'b0;
      end else if (st_reg.pin_ctrl[`RMCB_PEN_BIT] && pin_act) begin
         st_next.ref_en = st_reg.ref_alt_en;
         st_next.ref_alt = 1'b1;
      end else begin
         // Control source off or pin inactive: main settings
         st_next.ref_en = st_reg.ref_main_en;
         st_next.ref_alt = 1'b0;
      end
   end

   // ==========================================
   // State register
   // Everything clears to off; true defaults arrive with check-and-load,
   // so regulators stay off until the shadow values are valid.
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================
   // Outputs, all from flip-flops
   assign reg_rdata_o = st_reg.rdata;
   assign term_en_o = st_reg.term_en;
   assign term_sink_source_o = st_reg.term_snk;
   assign term_bypass_o = st_reg.term_byp;
   assign term_output_voltage_code_o = st_reg.term_vout;
   assign usb_en_o = st_reg.usb_en;
   assign usb_force_main_supply_o = st_reg.usb_fmain;
   assign usb_force_bus_supply_o = st_reg.usb_fbus;
   assign usb_auto_supply_o = st_reg.usb_auto;
   assign ref_en_o = st_reg.ref_en;
   assign ref_alt_active_o = st_reg.ref_alt;

endmodule // rmcb_bank
`default_nettype wire

// >>> tb/rmcb_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Host side of the register port
module rmcb_host_model (
   // Clock
   input wire logic ref_clk_i,
   // Requests towards the bank
   output logic [7:0] reg_addr_o,
   output logic reg_wr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_rd_o,
   // Read answer
   input wire logic [7:0] reg_rdata_i
);
   // Idle at time zero, strobes low
   initial begin
      reg_addr_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_wdata_o = 8'h00;
      reg_rd_o = 1'b0;
   end

   // One-cycle write; idle bus is scrambled so stale values cannot pass
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge ref_clk_i);
      reg_addr_o <= addr;
      reg_wdata_o <= data;
      reg_wr_o <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_o <= 1'b0;
      reg_addr_o <= ~addr;
      reg_wdata_o <= ~data;
   endtask

   // One-cycle read; data taken once the registered answer has settled
   task automatic rd(input logic [7:0] addr, output logic [7:0] data);
      @(posedge ref_clk_i);
      reg_addr_o <= addr;
      reg_rd_o <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~addr;
      @(posedge ref_clk_i);
      #1;
      data = reg_rdata_i;
   endtask
endmodule // rmcb_host_model

`default_nettype wire

// >>> tb/rmcb_bank_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "rmcb_map.svh"

// ==========================================
// Port-level checker for the bank
module rmcb_bank_monitor (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // Load and shadow defaults
   input wire logic check_load_i,
   input wire logic nvm_term_snk_i,
   input wire logic nvm_term_byp_i,
   input wire logic [4:0] nvm_term_vout_i,
   input wire logic [2:0] nvm_term_rank_i,
   input wire logic [2:0] usb_phy_regulator_rank_i,
   input wire logic [2:0] reference_regulator_rank_i,
   // Pins and mode selects
   input wire logic power_control_pin_one_i,
   input wire logic power_control_pin_two_i,
   input wire logic power_control_pin_three_i,
   input wire logic term_alt_sel_i,
   input wire logic usb_alt_sel_i,
   // Applied settings
   input wire logic term_en_o,
   input wire logic term_sink_source_o,
   input wire logic term_bypass_o,
   input wire logic [4:0] term_output_voltage_code_o,
   input wire logic usb_en_o,
   input wire logic usb_force_main_supply_o,
   input wire logic usb_force_bus_supply_o,
   input wire logic usb_auto_supply_o,
   input wire logic ref_en_o,
   input wire logic ref_alt_active_o
);
   // Ranks 1 to 5 load as enabled; 0, 6 and 7 as off
   wire logic term_on = (nvm_term_rank_i >= 3'h1) && (nvm_term_rank_i <= 3'h5);
   wire logic usb_on = (usb_phy_regulator_rank_i >= 3'h1) && (usb_phy_regulator_rank_i <= 3'h5);
   wire logic ref_on = (reference_regulator_rank_i >= 3'h1) && (reference_regulator_rank_i <= 3'h5);
   // Reads of the two reference and the two USB registers
   wire logic rd_ref = reg_rd_i && (reg_addr_i inside {`RMCB_REF_MAIN_ADDR, `RMCB_REF_ALT_ADDR});
   wire logic rd_usb = reg_rd_i && (reg_addr_i inside {`RMCB_USB_MAIN_ADDR, `RMCB_USB_ALT_ADDR});

   // Single domain, so clock and reset are stated once
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!nrst_i);

   // Applied outputs, two cycles after a load, equal the shadow values
   chk_load_term_code: assert property (check_load_i |-> ##2
      term_output_voltage_code_o == $past(nvm_term_vout_i, 2)
      && term_sink_source_o == $past(nvm_term_snk_i, 2))
      else $error("term code or sink after load differs from shadow");
   chk_load_term_mode: assert property (check_load_i |-> ##2
      term_bypass_o == $past(nvm_term_byp_i && !nvm_term_snk_i, 2)
      && term_en_o == $past(term_on, 2))
      else $error("term bypass or enable after load wrong");
   chk_load_usb: assert property (check_load_i |-> ##2
      usb_en_o == $past(usb_on, 2) && usb_auto_supply_o)
      else $error("usb enable or source after load wrong");
   chk_load_ref: assert property (check_load_i |-> ##2
      ref_en_o == $past(ref_on, 2) && !ref_alt_active_o)
      else $error("reference enable after load wrong");
   // Mode decodes never overlap
   chk_sink_wins: assert property (!(term_sink_source_o && term_bypass_o))
      else $error("sink/source and bypass applied together");
   chk_usb_src_excl: assert property ($onehot0({usb_force_main_supply_o,
      usb_force_bus_supply_o, usb_auto_supply_o}))
      else $error("usb supply selections overlap");
   // Reserved bits read back as zero
   chk_ref_rsvd_zero: assert property (rd_ref |=> reg_rdata_o[7:1] == 7'h00)
      else $error("reference reserved bits read nonzero");
   chk_usb_rsvd_zero: assert property (rd_usb |=> reg_rdata_o[5:1] == 5'h00)
      else $error("usb reserved bits read nonzero");
endmodule // rmcb_bank_monitor

bind rmcb_bank rmcb_bank_monitor u_mon (.*);

`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rmcb_map.svh"

// ==========================================
// Self-checking bench for the regulator bank
module tb_top;
   // Design inputs
   logic ref_clk_i, nrst_i, check_load_i, nvm_term_snk_i, nvm_term_byp_i;
   logic [4:0] nvm_term_vout_i;
   logic [2:0] nvm_term_rank_i, usb_phy_regulator_rank_i, reference_regulator_rank_i;
   logic power_control_pin_one_i, power_control_pin_two_i, power_control_pin_three_i;
   logic term_alt_sel_i, usb_alt_sel_i;
   // Register port, driven by the host model
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
   logic reg_wr_i, reg_rd_i;
   // Applied settings
   logic term_en_o, term_sink_source_o, term_bypass_o, usb_en_o, ref_en_o, ref_alt_active_o;
   logic [4:0] term_output_voltage_code_o;
   logic usb_force_main_supply_o, usb_force_bus_supply_o, usb_auto_supply_o;
   // Outputs packed as bytes for comparison
   wire logic [7:0] term_v = {term_sink_source_o, term_bypass_o, term_output_voltage_code_o,
      term_en_o};
   wire logic [7:0] usb_v = {4'h0, usb_en_o, usb_force_main_supply_o, usb_force_bus_supply_o,
      usb_auto_supply_o};
   wire logic [7:0] ref_v = {6'h00, ref_alt_active_o, ref_en_o};
   int num_errors = 0;
   int tests_run = 0;
   logic [7:0] rv;

   // Short delays keep the shift filter runs brief
   rmcb_bank #(.CYC_1P5(21'h3), .CYC_3(21'h6), .CYC_6(21'h0C)) u_dut (.*);
   rmcb_host_model u_host (.ref_clk_i(ref_clk_i), .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i),
      .reg_wdata_o(reg_wdata_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o));

   // ==========================================
   // Helpers
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp, input string name);
      u_host.rd(addr, rv);
      check(name, exp, rv);
   endtask
   task automatic load(input logic [2:0] tr, input logic [2:0] ur, input logic [2:0] rr);
      @(posedge ref_clk_i);
      nvm_term_rank_i <= tr;
      usb_phy_regulator_rank_i <= ur;
      reference_regulator_rank_i <= rr;
      check_load_i <= 1'b1;
      @(posedge ref_clk_i);
      check_load_i <= 1'b0;
      cyc(2);
   endtask
   task automatic pins(input logic [2:0] p);
      @(posedge ref_clk_i);
      {power_control_pin_three_i, power_control_pin_two_i, power_control_pin_one_i} <= p;
   endtask

   // ==========================================
   // Scenarios
   task automatic t_load;
      @(posedge ref_clk_i);
      {nvm_term_snk_i, nvm_term_byp_i, nvm_term_vout_i} <= 7'h75;
      u_host.wr(`RMCB_REF_PIN_ADDR, 8'hFF);
      load(3'h3, 3'h5, 3'h0);
      rdchk(`RMCB_TERM_MAIN_ADDR, 8'hEB, "term main");
      rdchk(`RMCB_TERM_ALT_ADDR, 8'hEB, "term alt");
      rdchk(`RMCB_USB_MAIN_ADDR, 8'h01, "usb main");
      rdchk(`RMCB_USB_ALT_ADDR, 8'h01, "usb alt");
      rdchk(`RMCB_REF_MAIN_ADDR, 8'h00, "ref main");
      rdchk(`RMCB_REF_ALT_ADDR, 8'h00, "ref alt");
      rdchk(`RMCB_REF_PIN_ADDR, 8'h00, "pin ctrl");
      check("term applied", 8'hAB, term_v);
      check("usb applied", 8'h09, usb_v);
   endtask
   // Boundary ranks, including the out-of-range code
   task automatic t_ranks;
      logic [2:0] rk [4] = '{3'h0, 3'h1, 3'h5, 3'h6};
      logic on;
      for (int i = 0; i < 4; i++) begin
         load(rk[i], rk[i], rk[i]);
         on = (rk[i] >= 3'h1) && (rk[i] <= 3'h5);
         check("usb en", {7'h00, on}, {7'h00, usb_en_o});
         check("ref en", {7'h00, on}, ref_v);
         check("term en", {7'h00, on}, {7'h00, term_en_o});
      end
   endtask
   task automatic t_term;
      u_host.wr(`RMCB_TERM_MAIN_ADDR, 8'h4B);
      cyc(2);
      check("term bypass", 8'h4B, term_v);
      u_host.wr(`RMCB_TERM_MAIN_ADDR, 8'h80);
      cyc(2);
      check("term sink", 8'h80, term_v);
      u_host.wr(`RMCB_TERM_ALT_ADDR, 8'h3E);
      @(posedge ref_clk_i) term_alt_sel_i <= 1'b1;
      cyc(3);
      check("term alt", 8'h3E, term_v);
      @(posedge ref_clk_i) term_alt_sel_i <= 1'b0;
      cyc(3);
   endtask
   // Every source code, with reserved bits written as ones
   task automatic t_usb;
      logic [7:0] exp [4] = '{8'h09, 8'h0C, 8'h0A, 8'h09};
      for (int c = 0; c < 4; c++) begin
         u_host.wr(`RMCB_USB_MAIN_ADDR, {c[1:0], 6'h3F});
         cyc(2);
         check("usb source", exp[c], usb_v);
      end
      rdchk(`RMCB_USB_MAIN_ADDR, 8'hC1, "usb readback");
      u_host.wr(`RMCB_USB_ALT_ADDR, 8'h40);
      @(posedge ref_clk_i) usb_alt_sel_i <= 1'b1;
      cyc(3);
      check("usb alt off", 8'h04, usb_v);
      @(posedge ref_clk_i) usb_alt_sel_i <= 1'b0;
   endtask
   task automatic t_ref_regs;
      u_host.wr(`RMCB_REF_MAIN_ADDR, 8'hFF);
      rdchk(`RMCB_REF_MAIN_ADDR, 8'h01, "ref readback");
      check("ref on", 8'h01, ref_v);
      u_host.wr(8'h67, 8'h5A);
      rdchk(8'h67, 8'h00, "unmapped");
   endtask
   // Every delay code on both edges, each pin in turn
   task automatic t_pin;
      int n [4] = '{1, 3, 6, 12};
      logic [1:0] s;
      u_host.wr(`RMCB_REF_ALT_ADDR, 8'h00);
      for (int k = 0; k < 4; k++) begin
         s = 2'(k % 3 + 1);
         // Fall code mirrors the rise code, so swapped edges cannot pass
         u_host.wr(`RMCB_REF_PIN_ADDR, {k[1:0], ~k[1:0], s, 2'h1});
         pins(3'h1 << (s - 2'h1));
         cyc(n[k]);
         check("ref before rise", 8'h01, ref_v);
         cyc(5);
         check("ref after rise", 8'h02, ref_v);
         pins(3'h0);
         cyc(n[3 - k]);
         check("ref before fall", 8'h02, ref_v);
         cyc(5);
         check("ref after fall", 8'h01, ref_v);
      end
      u_host.wr(`RMCB_REF_PIN_ADDR, 8'h01);
      pins(3'h7);
      cyc(6);
      check("ref no pin", 8'h01, ref_v);
      u_host.wr(`RMCB_REF_PIN_ADDR, 8'h04);
      cyc(6);
      check("ref main only", 8'h01, ref_v);
      pins(3'h0);
   endtask
   // Reset option holds the regulator off and restores the off default
   task automatic t_hold;
      u_host.wr(`RMCB_REF_PIN_ADDR, 8'h06);
      pins(3'h1);
      cyc(6);
      check("ref held", 8'h00, ref_v);
      u_host.wr(`RMCB_REF_MAIN_ADDR, 8'h01);
      rdchk(`RMCB_REF_MAIN_ADDR, 8'h00, "ref main held");
      pins(3'h0);
      cyc(6);
      check("ref released", 8'h00, ref_v);
   endtask

   // ==========================================
   // Verdict, reached from the main sequence or the watchdog
   task automatic results;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Clock at 200 MHz
   initial begin
      ref_clk_i = 1'b0;
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end

   // Main sequence
   initial begin
      {nrst_i, check_load_i, nvm_term_snk_i, nvm_term_byp_i, term_alt_sel_i} = 5'h00;
      {nvm_term_vout_i, nvm_term_rank_i, usb_phy_regulator_rank_i} = 11'h000;
      reference_regulator_rank_i = 3'h0;
      {usb_alt_sel_i, power_control_pin_one_i} = 2'h0;
      {power_control_pin_two_i, power_control_pin_three_i} = 2'h0;
      repeat (4) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      t_load();
      t_ranks();
      t_term();
      t_usb();
      t_ref_regs();
      t_pin();
      t_hold();
      results();
   end

   // Watchdog, far beyond the few hundred cycles the scenarios take
   initial begin
      #200000;
      num_errors++;
      $display("[ERR] watchdog expected done seen timeout");
      results();
   end
endmodule // tb_top

`default_nettype wire
